// File: rtl/dp_pkg.sv
// Purpose: shared constants of the datapath fifo and work register block
// Assumes: 8-bit datapath, two 4-byte fifos, one system clock
// Notes: register indices are those of the bus port of the top module
//
// What this block does
// - six 8-bit registers, bus readable; bus writable except a fifo in output direction
// - accumulators take alu, data register or fifo
// - wakeup clears accumulators and fifos to zero
// - data registers keep contents across sleep
// - two 4-byte fifos, independent directions
// - input: bus writes; output: bus reads
// - single-buffer: one byte, no status, overwritable
// - datapath load is level or rising edge
// - load sampled on datapath or bus clock
// - accumulator read pushes value into fifo
// - capture passes along chain to top tile
// - status to datapath direct, one or two syncs
// - per fifo clock polarity invert bit
// - source select 00 bus, 01/10 accumulators, 11 alu
// - static mux; input feeds registers, output bus
// - input bus status by level: one or two free
package dp_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int HALF_MARK = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // -------------------------------------------
    // register indices on the bus port
    // -------------------------------------------
    localparam logic [2:0] REG_ACC_ZERO = 3'h0;
    localparam logic [2:0] REG_ACC_ONE = 3'h1;
    localparam logic [2:0] REG_DATA_ZERO = 3'h2;
    localparam logic [2:0] REG_DATA_ONE = 3'h3;
    localparam logic [2:0] REG_FIFO_ZERO = 3'h4;
    localparam logic [2:0] REG_FIFO_ONE = 3'h5;
    // -------------------------------------------
    // fifo source select codes
    // -------------------------------------------
    localparam logic [1:0] SEL_BUS_IN = 2'h0;
    localparam logic [1:0] SEL_ACC_ZERO = 2'h1;
    localparam logic [1:0] SEL_ACC_ONE = 2'h2;
    localparam logic [1:0] SEL_ALU = 2'h3;
    // -------------------------------------------
    // accumulator load sources
    // -------------------------------------------
    localparam logic [1:0] ACC_HOLD = 2'h0;
    localparam logic [1:0] ACC_FROM_ALU = 2'h1;
    localparam logic [1:0] ACC_FROM_DATA = 2'h2;
    localparam logic [1:0] ACC_FROM_FIFO = 2'h3;
    // -------------------------------------------
    // status synchronisation modes
    // -------------------------------------------
    localparam logic [1:0] SYNC_DIRECT = 2'h0;
    localparam logic [1:0] SYNC_SINGLE = 2'h1;
    localparam logic [1:0] SYNC_DOUBLE = 2'h2;
endpackage

// File: rtl/fifo_if.sv
// Purpose: control and data between the datapath top and one fifo store
// Assumes: both ends on clock_in
// Notes: count is the fill level, zero while flushed
`timescale 1ns/100ps
interface fifo_if #(parameter int WIDTH = 8, parameter int DEPTH = 4);
    logic push;
    logic pop;
    logic flush;
    logic wipe;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] rdata;
    logic [$clog2(DEPTH):0] count;
    modport ctrl (output push, pop, flush, wipe, wdata, input rdata, count);
    modport store (input push, pop, flush, wipe, wdata, output rdata, count);
endinterface

// File: rtl/fifo_store.sv
// Purpose: small fifo with flush-to-single-buffer and wipe
// Assumes: depth at least two
// Notes: a push and a pop may meet in one cycle
`timescale 1ns/100ps
module fifo_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // control side
    fifo_if.store link
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    wire full = count_reg == FULL_CNT;
    wire empty = count_reg == '0;
    wire do_pop = link.pop & ~empty;
    wire do_push = link.push & (~full | do_pop);

    assign link.rdata = mem_reg[rd_ptr_reg];
    assign link.count = count_reg;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int k = 0; k < DEPTH; k++) begin
                mem_reg[k] <= '0;
            end
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (link.wipe) begin
            for (int k = 0; k < DEPTH; k++) begin
                mem_reg[k] <= '0;
            end
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (link.flush) begin
            // one byte, overwritable, read at once
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            if (link.push) begin
                mem_reg[0] <= link.wdata;
            end
        end else begin
            if (do_push) begin
                mem_reg[wr_ptr_reg] <= link.wdata;
                wr_ptr_reg <= step(wr_ptr_reg);
            end
            if (do_pop) begin
                rd_ptr_reg <= step(rd_ptr_reg);
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// File: rtl/datapath_fifo_and_work_regs.sv
// Purpose: datapath working registers and two fifos of one logic tile
// Assumes: datapath_clk arrives as a level sampled on clock_in
// Notes: bus read data is registered, one cycle after the strobe
`timescale 1ns/100ps
module datapath_fifo_and_work_regs #(
    parameter int WIDTH = dp_pkg::DATA_W,
    parameter int DEPTH = dp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // system bus port
    input wire logic [2:0] bus_addr_in,
    input wire logic bus_write_in,
    input wire logic bus_read_in,
    input wire logic [WIDTH-1:0] bus_wdata_in,
    output logic [WIDTH-1:0] bus_rdata_out,
    // datapath side
    input wire logic datapath_clk_in,
    input wire logic [WIDTH-1:0] alu_result_in,
    input wire logic [1:0] fifo_load_in,
    input wire logic [1:0] fifo_take_in,
    input wire logic [1:0] acc_zero_src_in,
    input wire logic [1:0] acc_one_src_in,
    input wire logic [1:0] data_load_in,
    // static configuration
    input wire logic [1:0] fifo_zero_source_select_in,
    input wire logic [1:0] fifo_one_source_select_in,
    input wire logic [1:0] fifo_level_select_in,
    input wire logic fifo_zero_flush_in,
    input wire logic fifo_one_flush_in,
    input wire logic [1:0] fifo_clock_invert_in,
    input wire logic load_edge_mode_in,
    input wire logic load_fast_mode_in,
    input wire logic soft_capture_en_in,
    input wire logic chain_en_in,
    input wire logic [1:0] status_sync_mode_in,
    // power
    input wire logic wake_clear_in,
    // chaining
    input wire logic chain_capture_in,
    output logic chain_capture_out,
    // state
    output logic [WIDTH-1:0] acc_zero_out,
    output logic [WIDTH-1:0] acc_one_out,
    output logic [1:0] bus_status_out,
    output logic [1:0] block_status_out
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_CNT = CW'(dp_pkg::HALF_MARK);
    localparam logic [CW-1:0] ROOM_TWO = CW'(DEPTH - dp_pkg::HALF_MARK);

    function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
        hit = a == idx;
    endfunction

    // ---------------------------------------------------------------
    // synchronisers for routed inputs
    // ---------------------------------------------------------------
    logic [4:0] meta_reg;
    logic [4:0] sync_reg;
    logic dp_prev_reg;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= {fifo_take_in, fifo_load_in, datapath_clk_in};
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dp_prev_reg <= 1'b0;
        end else begin
            dp_prev_reg <= sync_reg[0];
        end
    end

    wire dp_rise = sync_reg[0] & ~dp_prev_reg;
    wire dp_fall = ~sync_reg[0] & dp_prev_reg;
    wire [1:0] load_sync = sync_reg[2:1];
    wire [1:0] take_sync = sync_reg[4:3];

    // ---------------------------------------------------------------
    // bus decode and shared wires
    // ---------------------------------------------------------------
    wire [WIDTH-1:0] acc_w [2];
    wire [WIDTH-1:0] data_w [2];
    wire [WIDTH-1:0] head_w [2];
    wire [1:0] bus_stat_next;
    wire [1:0] blk_stat_next;
    wire [1:0] local_cap;

    wire rd_acc0 = bus_read_in & hit(bus_addr_in, dp_pkg::REG_ACC_ZERO);
    wire rd_acc1 = bus_read_in & hit(bus_addr_in, dp_pkg::REG_ACC_ONE);
    wire chain_hit = chain_en_in & chain_capture_in;

    // ---------------------------------------------------------------
    // per-fifo lanes: working registers, fifo, status
    // ---------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : lane
        fifo_if #(.WIDTH(WIDTH), .DEPTH(DEPTH)) fl ();

        fifo_store #(.WIDTH(WIDTH), .DEPTH(DEPTH)) store (
            .clock_in(clock_in),
            .reset_n_in(reset_n_in),
            .link(fl.store)
        );

        logic [WIDTH-1:0] acc_reg;
        logic [WIDTH-1:0] acc_next;
        logic [WIDTH-1:0] data_reg;
        logic ld_prev_reg;

        wire [1:0] sel = (i == 0) ? fifo_zero_source_select_in : fifo_one_source_select_in;
        wire [1:0] acc_src = (i == 0) ? acc_zero_src_in : acc_one_src_in;
        wire flush = (i == 0) ? fifo_zero_flush_in : fifo_one_flush_in;
        wire [2:0] acc_idx = (i == 0) ? dp_pkg::REG_ACC_ZERO : dp_pkg::REG_ACC_ONE;
        wire [2:0] data_idx = (i == 0) ? dp_pkg::REG_DATA_ZERO : dp_pkg::REG_DATA_ONE;
        wire [2:0] fifo_idx = (i == 0) ? dp_pkg::REG_FIFO_ZERO : dp_pkg::REG_FIFO_ONE;
        wire out_dir = sel != dp_pkg::SEL_BUS_IN;
        wire tick = fifo_clock_invert_in[i] ? dp_fall : dp_rise;
        wire sample = load_fast_mode_in | tick;
        wire wr_acc = bus_write_in & hit(bus_addr_in, acc_idx);
        wire wr_data = bus_write_in & hit(bus_addr_in, data_idx);
        wire wr_fifo = bus_write_in & hit(bus_addr_in, fifo_idx);
        wire rd_fifo = bus_read_in & hit(bus_addr_in, fifo_idx);
        wire acc_from_fifo = dp_rise & (acc_src == dp_pkg::ACC_FROM_FIFO);
        wire data_from_fifo = dp_rise & data_load_in[i];

        // hardware load: level, or rising edge of the sampled control
        wire hw_load = sample & load_sync[i] & (~load_edge_mode_in | ~ld_prev_reg);
        wire rd_own = (i == 0) ? rd_acc0 : rd_acc1;
        wire sw_cap = soft_capture_en_in & out_dir & (rd_own | chain_hit);
        wire consume = (tick & take_sync[i]) | acc_from_fifo | data_from_fifo;

        assign local_cap[i] = soft_capture_en_in & rd_own;

        // static source mux for the fifo write port
        wire [WIDTH-1:0] src_data =
            (sel == dp_pkg::SEL_ACC_ZERO) ? acc_w[0] :
            (sel == dp_pkg::SEL_ACC_ONE) ? acc_w[1] :
            alu_result_in;

        assign fl.push = out_dir ? (hw_load | sw_cap) : wr_fifo;
        assign fl.pop = out_dir ? rd_fifo : consume;
        assign fl.wdata = out_dir ? (sw_cap ? acc_reg : src_data) : bus_wdata_in;
        assign fl.flush = flush;
        assign fl.wipe = wake_clear_in;

        always_ff @(posedge clock_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                ld_prev_reg <= 1'b0;
            end else if (sample) begin
                ld_prev_reg <= load_sync[i];
            end
        end

        // accumulator: bus write wins over datapath load
        always_comb begin
            acc_next = acc_reg;
            if (wr_acc) begin
                acc_next = bus_wdata_in;
            end else if (dp_rise) begin
                case (acc_src)
                    dp_pkg::ACC_FROM_ALU: begin
                        acc_next = alu_result_in;
                    end
                    dp_pkg::ACC_FROM_DATA: begin
                        acc_next = data_reg;
                    end
                    dp_pkg::ACC_FROM_FIFO: begin
                        acc_next = fl.rdata;
                    end
                    default: begin
                        acc_next = acc_reg;
                    end
                endcase
            end
        end

        always_ff @(posedge clock_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                acc_reg <= dp_pkg::RESET_BYTE;
            end else if (wake_clear_in) begin
                acc_reg <= dp_pkg::RESET_BYTE;
            end else begin
                acc_reg <= acc_next;
            end
        end

        // data register ignores wakeup
        always_ff @(posedge clock_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                data_reg <= dp_pkg::RESET_BYTE;
            end else if (wr_data) begin
                data_reg <= bus_wdata_in;
            end else if (data_from_fifo) begin
                data_reg <= fl.rdata;
            end
        end

        assign acc_w[i] = acc_reg;
        assign data_w[i] = data_reg;
        assign head_w[i] = fl.rdata;

        // status levels, silent while flushed
        wire [CW-1:0] cnt = fl.count;
        wire in_stat = fifo_level_select_in[i] ? (cnt <= ROOM_TWO) : (cnt < FULL_CNT);
        wire out_stat = fifo_level_select_in[i] ? (cnt >= HALF_CNT) : (cnt != '0);
        assign bus_stat_next[i] = ~flush & (out_dir ? out_stat : in_stat);
        assign blk_stat_next[i] = ~flush & (out_dir ? (cnt == FULL_CNT) : (cnt == '0));
    end

    // ---------------------------------------------------------------
    // block status toward the datapath
    // ---------------------------------------------------------------
    logic [1:0] blk_one_reg;
    logic [1:0] blk_two_reg;
    logic [1:0] block_status_reg;
    logic [1:0] bus_status_reg;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            blk_one_reg <= '0;
            blk_two_reg <= '0;
        end else if (dp_rise) begin
            blk_one_reg <= blk_stat_next;
            blk_two_reg <= blk_one_reg;
        end
    end

    wire [1:0] blk_sel =
        (status_sync_mode_in == dp_pkg::SYNC_SINGLE) ? blk_one_reg :
        (status_sync_mode_in == dp_pkg::SYNC_DOUBLE) ? blk_two_reg :
        blk_stat_next;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            block_status_reg <= '0;
            bus_status_reg <= '0;
        end else begin
            block_status_reg <= blk_sel;
            bus_status_reg <= bus_stat_next;
        end
    end

    assign block_status_out = block_status_reg;
    assign bus_status_out = bus_status_reg;

    // ---------------------------------------------------------------
    // capture chain toward the most significant tile
    // ---------------------------------------------------------------
    logic chain_reg;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            chain_reg <= 1'b0;
        end else begin
            chain_reg <= chain_en_in & (|local_cap | chain_hit);
        end
    end

    assign chain_capture_out = chain_reg;

    // ---------------------------------------------------------------
    // bus read data
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] rdata_reg;

    wire [WIDTH-1:0] rdata_sel =
        hit(bus_addr_in, dp_pkg::REG_ACC_ZERO) ? acc_w[0] :
        hit(bus_addr_in, dp_pkg::REG_ACC_ONE) ? acc_w[1] :
        hit(bus_addr_in, dp_pkg::REG_DATA_ZERO) ? data_w[0] :
        hit(bus_addr_in, dp_pkg::REG_DATA_ONE) ? data_w[1] :
        hit(bus_addr_in, dp_pkg::REG_FIFO_ZERO) ? head_w[0] :
        hit(bus_addr_in, dp_pkg::REG_FIFO_ONE) ? head_w[1] :
        dp_pkg::RESET_BYTE;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_reg <= dp_pkg::RESET_BYTE;
        end else if (bus_read_in) begin
            rdata_reg <= rdata_sel;
        end
    end

    assign bus_rdata_out = rdata_reg;
    assign acc_zero_out = acc_w[0];
    assign acc_one_out = acc_w[1];
endmodule

// File: testbench/datapath_checker_assertions.sv
// Purpose: port-level checks of the datapath register and fifo block
// Assumes: one clock domain, read data registered one cycle after the strobe
// Notes: attached by bind from the bench top
`timescale 1ns/100ps
module datapath_checker_assertions #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // watched inputs
    input wire logic [2:0] bus_addr_in,
    input wire logic bus_write_in,
    input wire logic bus_read_in,
    input wire logic [WIDTH-1:0] bus_wdata_in,
    input wire logic [1:0] acc_zero_src_in,
    input wire logic wake_clear_in,
    input wire logic soft_capture_en_in,
    input wire logic chain_en_in,
    input wire logic chain_capture_in,
    input wire logic fifo_one_flush_in,
    // watched outputs
    input wire logic [WIDTH-1:0] bus_rdata_out,
    input wire logic chain_capture_out,
    input wire logic [WIDTH-1:0] acc_zero_out,
    input wire logic [WIDTH-1:0] acc_one_out,
    input wire logic [1:0] bus_status_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    // ---------------------------------------
    // bus port
    // ---------------------------------------
    property p_unmapped_zero;
        bus_read_in && bus_addr_in > 3'h5 |=> bus_rdata_out == '0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");
    property p_rdata_hold;
        !bus_read_in |=> $stable(bus_rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_acc0_write;
        bus_write_in && bus_addr_in == dp_pkg::REG_ACC_ZERO && !wake_clear_in
            |=> acc_zero_out == $past(bus_wdata_in);
    endproperty
    a_acc0_write: assert property (p_acc0_write) else $error("accumulator write lost");
    property p_acc1_read;
        bus_read_in && bus_addr_in == dp_pkg::REG_ACC_ONE |=> bus_rdata_out == $past(acc_one_out);
    endproperty
    a_acc1_read: assert property (p_acc1_read) else $error("accumulator read wrong");
    // ---------------------------------------
    // accumulators, chain and flush status
    // ---------------------------------------
    property p_wake_clear;
        wake_clear_in && !bus_write_in |=> acc_zero_out == '0 && acc_one_out == '0;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wakeup clear");
    property p_acc_hold;
        acc_zero_src_in == dp_pkg::ACC_HOLD && !bus_write_in && !wake_clear_in |=> $stable(acc_zero_out);
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("accumulator hold");
    property p_chain_fwd;
        chain_en_in && chain_capture_in |=> chain_capture_out;
    endproperty
    a_chain_fwd: assert property (p_chain_fwd) else $error("chain capture not passed on");
    property p_chain_off;
        !chain_en_in |=> !chain_capture_out;
    endproperty
    a_chain_off: assert property (p_chain_off) else $error("chain capture without chaining");
    property p_flush_quiet;
        fifo_one_flush_in [*3] |-> !bus_status_out[1];
    endproperty
    a_flush_quiet: assert property (p_flush_quiet) else $error("status shown while flushed");
    c_soft_read: cover property (bus_read_in && bus_addr_in == dp_pkg::REG_ACC_ONE && soft_capture_en_in);
    c_wake: cover property (wake_clear_in);
    c_chain: cover property (chain_capture_out);
endmodule

// File: testbench/bus_master_model.sv
// Purpose: processor side of the register port
// Assumes: one-cycle strobes taken on the rising clock edge
// Notes: write data is inverted once released
`timescale 1ns/100ps
module bus_master_model (
    // clock
    input wire logic clock_in,
    // register port
    output logic [2:0] bus_addr_out,
    output logic bus_write_out,
    output logic bus_read_out,
    output logic [7:0] bus_wdata_out,
    input wire logic [7:0] bus_rdata_in
);
    initial begin
        bus_addr_out = 3'h0;
        bus_write_out = 1'b0;
        bus_read_out = 1'b0;
        bus_wdata_out = 8'h00;
    end
    task automatic write_reg(input logic [2:0] addr, input logic [7:0] data);
        @(posedge clock_in);
        #1;
        bus_addr_out = addr;
        bus_wdata_out = data;
        bus_write_out = 1'b1;
        @(posedge clock_in);
        #1;
        bus_write_out = 1'b0;
        bus_wdata_out = ~data;
    endtask
    task automatic read_reg(input logic [2:0] addr, output logic [7:0] data);
        @(posedge clock_in);
        #1;
        bus_addr_out = addr;
        bus_read_out = 1'b1;
        @(posedge clock_in);
        #1;
        bus_read_out = 1'b0;
        data = bus_rdata_in;
    endtask
endmodule

// File: testbench/test_datapath_fifo_and_work_regs.sv
// Purpose: self-checking bench of the datapath registers and fifos
// Assumes: bus master model drives the register port
// Notes: datapath clock is clock_in divided by eight
`timescale 1ns/100ps
module test_datapath_fifo_and_work_regs;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] bus_addr_in, dp_cnt = 3'h0;
    logic bus_write_in, bus_read_in, chain_capture_out;
    logic [7:0] bus_wdata_in, bus_rdata_out, acc_zero_out, acc_one_out, rd;
    logic [7:0] alu_result_in = 8'h00;
    logic [1:0] fifo_load_in = 2'h0, acc_zero_src_in = 2'h0, fifo_level_select_in = 2'h0;
    logic [1:0] fifo_zero_source_select_in = 2'h0, fifo_one_source_select_in = 2'h0;
    logic [1:0] bus_status_out, block_status_out;
    logic fifo_zero_flush_in = 1'b0, fifo_one_flush_in = 1'b0, wake_clear_in = 1'b0;
    logic load_edge_mode_in = 1'b0, load_fast_mode_in = 1'b0, soft_capture_en_in = 1'b0;
    logic chain_en_in = 1'b0, chain_capture_in = 1'b0;
    wire datapath_clk_in = dp_cnt[2];
    int error_cnt = 0;
    int n_tests = 0;

    always #2.5 clock_in = ~clock_in;
    always @(posedge clock_in) dp_cnt <= #1 dp_cnt + 3'h1;

    bus_master_model host (.clock_in(clock_in), .bus_addr_out(bus_addr_in), .bus_write_out(bus_write_in),
        .bus_read_out(bus_read_in), .bus_wdata_out(bus_wdata_in), .bus_rdata_in(bus_rdata_out));

    datapath_fifo_and_work_regs dut (.*, .fifo_take_in(2'h0), .acc_one_src_in(2'h0), .data_load_in(2'h0),
        .fifo_clock_invert_in(2'h0), .status_sync_mode_in(2'h0));

    // ---------------------------------------
    // helpers
    // ---------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic read_check(input logic [2:0] addr, input logic [7:0] exp);
        host.read_reg(addr, rd);
        check_byte(rd, exp);
    endtask
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ---------------------------------------
    // scenarios
    // ---------------------------------------
    task automatic t_rw_regs();
        logic [7:0] vals [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
        for (int a = 0; a < 8; a++) begin
            read_check(a[2:0], 8'h00);
        end
        for (int a = 0; a < 4; a++) begin
            host.write_reg(a[2:0], vals[a]);
        end
        for (int a = 0; a < 4; a++) begin
            read_check(a[2:0], vals[a]);
        end
    endtask
    task automatic t_wake();
        host.write_reg(dp_pkg::REG_FIFO_ZERO, 8'h9C);
        wake_clear_in = 1'b1;
        step(1);
        wake_clear_in = 1'b0;
        read_check(dp_pkg::REG_ACC_ZERO, 8'h00);
        read_check(dp_pkg::REG_ACC_ONE, 8'h00);
        read_check(dp_pkg::REG_DATA_ZERO, 8'h56);
        read_check(dp_pkg::REG_DATA_ONE, 8'h78);
        read_check(dp_pkg::REG_FIFO_ZERO, 8'h00);
    endtask
    task automatic t_input_fifo();
        logic [7:0] seq [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        for (int i = 0; i < 3; i++) begin
            host.write_reg(dp_pkg::REG_FIFO_ZERO, seq[i]);
        end
        step(2);
        check_bit(bus_status_out[0], 1'b1);
        fifo_level_select_in = 2'h1;
        step(2);
        check_bit(bus_status_out[0], 1'b0);
        fifo_level_select_in = 2'h0;
        host.write_reg(dp_pkg::REG_FIFO_ZERO, seq[3]);
        host.write_reg(dp_pkg::REG_FIFO_ZERO, seq[4]);
        step(2);
        check_bit(bus_status_out[0], 1'b0);
        check_bit(block_status_out[0], 1'b0);
        for (int i = 0; i < 4; i++) begin
            acc_zero_src_in = dp_pkg::ACC_FROM_FIFO;
            for (int k = 0; k < 40 && acc_zero_out !== seq[i]; k++) begin
                step(1);
            end
            acc_zero_src_in = dp_pkg::ACC_HOLD;
            check_byte(acc_zero_out, seq[i]);
        end
        step(2);
        check_bit(bus_status_out[0], 1'b1);
        check_bit(block_status_out[0], 1'b1);
    endtask
    task automatic t_single_buffer();
        fifo_one_flush_in = 1'b1;
        host.write_reg(dp_pkg::REG_FIFO_ONE, 8'hAA);
        host.write_reg(dp_pkg::REG_FIFO_ONE, 8'hBB);
        read_check(dp_pkg::REG_FIFO_ONE, 8'hBB);
        check_bit(bus_status_out[1], 1'b0);
        fifo_one_flush_in = 1'b0;
    endtask
    task automatic t_soft_capture();
        fifo_one_source_select_in = dp_pkg::SEL_ACC_ONE;
        soft_capture_en_in = 1'b1;
        chain_en_in = 1'b1;
        fifo_one_flush_in = 1'b1;
        step(2);
        fifo_one_flush_in = 1'b0;
        host.write_reg(dp_pkg::REG_ACC_ONE, 8'h5A);
        host.read_reg(dp_pkg::REG_ACC_ONE, rd);
        check_bit(chain_capture_out, 1'b1);
        read_check(dp_pkg::REG_FIFO_ONE, 8'h5A);
        host.write_reg(dp_pkg::REG_ACC_ONE, 8'h6B);
        chain_capture_in = 1'b1;
        step(1);
        chain_capture_in = 1'b0;
        read_check(dp_pkg::REG_FIFO_ONE, 8'h6B);
        soft_capture_en_in = 1'b0;
        host.read_reg(dp_pkg::REG_ACC_ONE, rd);
        step(2);
        check_bit(bus_status_out[1], 1'b0);
        chain_en_in = 1'b0;
    endtask
    task automatic t_hw_load();
        fifo_zero_source_select_in = dp_pkg::SEL_ALU;
        load_fast_mode_in = 1'b1;
        load_edge_mode_in = 1'b1;
        alu_result_in = 8'h3C;
        fifo_zero_flush_in = 1'b1;
        step(2);
        fifo_zero_flush_in = 1'b0;
        fifo_load_in = 2'h1;
        step(4);
        fifo_load_in = 2'h0;
        step(4);
        read_check(dp_pkg::REG_FIFO_ZERO, 8'h3C);
        step(2);
        check_bit(bus_status_out[0], 1'b0);
        load_edge_mode_in = 1'b0;
        alu_result_in = 8'h4D;
        fifo_load_in = 2'h1;
        step(2);
        fifo_load_in = 2'h0;
        step(4);
        fifo_level_select_in = 2'h1;
        step(2);
        check_bit(bus_status_out[0], 1'b1);
        read_check(dp_pkg::REG_FIFO_ZERO, 8'h4D);
        read_check(dp_pkg::REG_FIFO_ZERO, 8'h4D);
        fifo_level_select_in = 2'h0;
    endtask
    // ---------------------------------------
    // main sequence and watchdog
    // ---------------------------------------
    initial begin
        repeat (20) @(posedge clock_in);
        #1;
        reset_n_in = 1'b1;
        step(4);
        t_rw_regs();
        t_wake();
        t_input_fifo();
        t_single_buffer();
        t_soft_capture();
        t_hw_load();
        print_verdict();
    end
    initial begin
        #50000;
        error_cnt++;
        print_verdict();
    end
endmodule

bind datapath_fifo_and_work_regs datapath_checker_assertions #(.WIDTH(WIDTH)) u_chk (.*);
